// File: core/isk_pkg.sv
// Package with opcodes, field layouts, reset values and types for the increment-skip unit.
package isk_pkg;
  localparam logic [5:0] OP_INC_SKIP_ZERO = 6'h0F;
  localparam logic [5:0] OP_INC_SKIP_NONZERO = 6'h12;
  localparam int OPC_MSB = 15;
  localparam int OPC_LSB = 10;
  localparam int DEST_BIT = 9;
  localparam int BANK_BIT = 8;
  localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [1:0] PHASE_RESET = 2'h0;
  localparam logic [1:0] IDLE_RESET = 2'h0;
  localparam logic [7:0] WREG_RESET = 8'h00;

  // Operand address request: bank plus offset, or indexed offset from the frame pointer.
  typedef struct packed {
    logic valid;
    logic indexed;
    logic [3:0] bank;
    logic [7:0] offset;
  } isk_addr_t;

  // Write request toward the data memory.
  typedef struct packed {
    logic valid;
    logic [3:0] bank;
    logic [7:0] offset;
    logic indexed;
    logic [7:0] data;
  } isk_write_t;
endpackage : isk_pkg

// File: core/isk_phase_gen.sv
// Four-phase instruction cycle generator.
`timescale 1ns/1ps
module isk_phase_gen (
  input wire logic clock, // Core clock.
  input wire logic rst, // Asynchronous reset, active high.
  output logic [1:0] phase, // Current phase, 0 to 3.
  output logic cycle_end // High in the last phase of each cycle.
);
  logic [1:0] phase_q;
  logic [1:0] phase_d;

  // Next phase wraps after the fourth.
  always_comb begin
    phase_d = phase_q + 2'h1;
  end

  // Phase register.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase_q <= isk_pkg::PHASE_RESET;
    end else begin
      phase_q <= phase_d;
    end
  end

  assign phase = phase_q;
  assign cycle_end = (phase_q == 2'h3);
endmodule : isk_phase_gen

// File: core/isk_exec.sv
// Execution unit for the two increment-and-skip instructions.
`timescale 1ns/1ps
module isk_exec (
  input wire logic clock, // Core clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic [15:0] instr, // Instruction word in execution.
  input wire logic instr_valid, // Instruction word is valid for this cycle.
  input wire logic next_two_word, // Already fetched next instruction has two words.
  input wire logic ext_set_en, // Extended instruction set enabled.
  input wire logic [3:0] bank_select_register, // Bank for general_purpose_ram accesses.
  input wire logic [7:0] rd_data, // Operand returned by data memory.
  output isk_pkg::isk_addr_t rd_req, // Operand read request, phase two.
  output isk_pkg::isk_write_t wr_req, // File write request, in the phase after phase four.
  output logic [7:0] wreg, // Working register.
  output logic flush, // Next fetched word is discarded.
  output logic exec_busy, // Idle skip cycle under way.
  output logic status_we, // Status flag write, always low here.
  output logic [1:0] phase_out // Phase, delayed by one clock.
);
  logic [1:0] phase; // Phase from the generator.
  logic cycle_end; // Last phase of a cycle.
  typedef enum logic [1:0] {ISK_RUN, ISK_SKIP} isk_state_t;
  isk_state_t state_q; // Sequencer state.
  isk_state_t state_d;
  logic [1:0] idle_q; // Idle cycles still to run.
  logic [1:0] idle_d;
  logic is_zero_op; // Word is the skip-on-zero form.
  logic is_nz_op; // Word is the skip-on-nonzero form.
  logic hit; // Word is taken in this cycle.
  logic skip_take; // Skip decided in phase four.
  logic [7:0] opnd_q; // Operand read in phase two.
  logic [7:0] opnd_d;
  logic [7:0] sum_q; // Incremented value.
  logic [7:0] sum_d;
  logic [7:0] wreg_q; // Working register.
  logic [7:0] wreg_d;
  isk_pkg::isk_addr_t rd_q; // Read request.
  isk_pkg::isk_addr_t rd_d;
  isk_pkg::isk_write_t wr_q; // Write request.
  isk_pkg::isk_write_t wr_d;
  logic flush_q; // Discard of the fetched word.
  logic flush_d;
  logic busy_q; // Idle cycle under way.
  logic busy_d;
  logic [1:0] phase_q; // Phase copy for the core.
  logic [1:0] phase_d;
  logic status_q; // Status flag write, held low.
  logic status_d;

  isk_phase_gen u_phase (
    .clock(clock),
    .rst(rst),
    .phase(phase),
    .cycle_end(cycle_end)
  );

  // Opcode decode of the top six bits.
  assign is_zero_op = instr[isk_pkg::OPC_MSB:isk_pkg::OPC_LSB]
    == isk_pkg::OP_INC_SKIP_ZERO;
  assign is_nz_op = instr[isk_pkg::OPC_MSB:isk_pkg::OPC_LSB]
    == isk_pkg::OP_INC_SKIP_NONZERO;
  assign hit = instr_valid && (state_q == ISK_RUN) && (is_zero_op || is_nz_op);

  // Skip condition, judged in phase four from the incremented value.
  assign skip_take = hit && (phase == 2'h3)
    && ((is_zero_op && sum_q == 8'h00) || (is_nz_op && sum_q != 8'h00));

  // Operand address: formed at decode, held through phase four, dropped after it.
  always_comb begin
    rd_d = '0;
    if (hit && phase == 2'h0) begin
      rd_d.valid = 1'b1;
      rd_d.offset = instr[7:0];
      if (instr[isk_pkg::BANK_BIT]) begin
        rd_d.bank = bank_select_register;
      end else if (ext_set_en && instr[7:0] <= isk_pkg::INDEXED_LIMIT) begin
        rd_d.indexed = 1'b1;
      end else if (instr[7:0] < isk_pkg::ACCESS_SPLIT) begin
        rd_d.bank = 4'h0;
      end else begin
        rd_d.bank = isk_pkg::ACCESS_HIGH_BANK;
      end
    end else if (hit && phase != 2'h3) begin
      rd_d = rd_q;
    end
  end

  // Address register; the file write in phase four reuses its fields.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_q <= '0;
    end else begin
      rd_q <= rd_d;
    end
  end

  // Datapath next values: capture, increment, then write one destination.
  always_comb begin
    opnd_d = opnd_q;
    sum_d = sum_q;
    wreg_d = wreg_q;
    wr_d = '0;
    if (hit && phase == 2'h1) begin
      opnd_d = rd_data;
    end else if (hit && phase == 2'h2) begin
      sum_d = opnd_q + 8'h01;
    end else if (hit && phase == 2'h3) begin
      if (instr[isk_pkg::DEST_BIT]) begin
        wr_d.valid = 1'b1;
        wr_d.bank = rd_q.bank;
        wr_d.offset = rd_q.offset;
        wr_d.indexed = rd_q.indexed;
        wr_d.data = sum_q;
      end else begin
        wreg_d = sum_q;
      end
    end
  end

  // Datapath registers; the write request lasts one clock.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      opnd_q <= 8'h00;
      sum_q <= 8'h00;
      wreg_q <= isk_pkg::WREG_RESET;
      wr_q <= '0;
    end else begin
      opnd_q <= opnd_d;
      sum_q <= sum_d;
      wreg_q <= wreg_d;
      wr_q <= wr_d;
    end
  end

  // Sequencer next values: idle cycles after a taken skip, one per skipped word.
  always_comb begin
    state_d = state_q;
    idle_d = idle_q;
    flush_d = 1'b0;
    busy_d = 1'b0;
    case (state_q)
      ISK_RUN: begin
        if (skip_take) begin
          state_d = ISK_SKIP;
          idle_d = next_two_word ? 2'h2 : 2'h1;
          flush_d = 1'b1;
          busy_d = 1'b1;
        end
      end
      ISK_SKIP: begin
        // Idle cycles do nothing in any phase.
        flush_d = 1'b1;
        busy_d = 1'b1;
        if (cycle_end) begin
          idle_d = idle_q - 2'h1;
          if (idle_q == 2'h1) begin
            state_d = ISK_RUN;
            flush_d = 1'b0;
            busy_d = 1'b0;
          end
        end
      end
      default: begin
        state_d = ISK_RUN;
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= ISK_RUN;
      idle_q <= isk_pkg::IDLE_RESET;
      flush_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      idle_q <= idle_d;
      flush_q <= flush_d;
      busy_q <= busy_d;
    end
  end

  // Phase copy for the rest of the core; the status write never rises.
  always_comb begin
    phase_d = phase;
    status_d = 1'b0;
  end

  // Mirror registers, so every output leaves a flip-flop.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase_q <= isk_pkg::PHASE_RESET;
      status_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      status_q <= status_d;
    end
  end

  // Outputs straight from their registers.
  assign rd_req = rd_q;
  assign wr_req = wr_q;
  assign wreg = wreg_q;
  assign flush = flush_q;
  assign exec_busy = busy_q;
  assign status_we = status_q;
  assign phase_out = phase_q;
endmodule : isk_exec

// File: bench/isk_exec_checker.sv
// Concurrent checks on the ports of the increment-skip execution unit.
`timescale 1ns/1ps
module isk_exec_checker (
  input wire logic clock, // Core clock.
  input wire logic rst, // Reset.
  input wire logic [15:0] instr, // Word in execution.
  input wire logic ext_set_en, // Extended set.
  input wire logic next_two_word, // Follower has two words.
  input wire logic [3:0] bank_select_register, // Bank.
  input wire isk_pkg::isk_addr_t rd_req, // Read request.
  input wire isk_pkg::isk_write_t wr_req, // Write request.
  input wire logic [7:0] wreg, // Working register.
  input wire logic flush, // Discard.
  input wire logic exec_busy, // Idle cycle.
  input wire logic status_we // Flag write.
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // The read spans phases two to four; a discard lasts one full cycle per skipped word.
  sequence s_rd_span;
    rd_req.valid [*3] ##1 !rd_req.valid;
  endsequence
  sequence s_fl_span;
    flush [*4];
  endsequence
  sequence s_idle_one;
    flush [*4] ##1 !flush;
  endsequence
  sequence s_idle_two;
    flush [*8] ##1 !flush;
  endsequence
  AST_SKIP_ONE: assert property ($rose(flush) && !$past(next_two_word) |-> s_idle_one)
    else $error("one-word skip length wrong");
  AST_SKIP_TWO: assert property ($rose(flush) && $past(next_two_word) |-> s_idle_two)
    else $error("two-word skip length wrong");
  AST_ACCESS_LOW: assert property (rd_req.valid && !instr[8] && !ext_set_en
    && instr[7:0] < 8'h60 |-> rd_req.bank == 4'h0 && !rd_req.indexed)
    else $error("low access bank wrong");
  AST_RD_SPAN: assert property ($rose(rd_req.valid) |-> s_rd_span)
    else $error("read span wrong");
  AST_FLUSH_LEN: assert property ($rose(flush) |-> s_fl_span)
    else $error("discard too short");
  AST_IDLE: assert property (exec_busy |-> !rd_req.valid)
    else $error("read in idle cycle");
  AST_STATUS: assert property (!status_we)
    else $error("status written");
  AST_BANK: assert property (rd_req.valid && instr[8]
    |-> rd_req.bank == bank_select_register)
    else $error("bank select ignored");
  AST_ACCESS: assert property (rd_req.valid && !instr[8] && instr[7:0] >= 8'h60
    |-> rd_req.bank == 4'hF)
    else $error("access bank wrong");
  AST_INDEXED: assert property (rd_req.valid && !instr[8] && ext_set_en
    && instr[7:0] <= 8'h5F |-> rd_req.indexed && rd_req.offset == instr[7:0])
    else $error("indexed mode missed");
  AST_WR_PULSE: assert property (wr_req.valid |-> $stable(wreg) ##1 !wr_req.valid)
    else $error("write pulse wrong");
  AST_WR_DEST: assert property ($fell(rd_req.valid) && $past(instr[9]) |-> wr_req.valid)
    else $error("file write missing");
endmodule : isk_exec_checker
bind isk_exec isk_exec_checker i_chk (.clock, .rst, .instr, .ext_set_en, .next_two_word,
  .bank_select_register,
  .rd_req, .wr_req, .wreg, .flush, .exec_busy, .status_we);

// File: bench/testbench.sv
// Self-checking bench for the increment-skip execution unit.
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [15:0] ins;
    logic [7:0] rd;
    logic tw;
    logic [7:0] w;
    logic fl;
    logic wr;
  } isk_row_t;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic [15:0] instr = 16'h0000;
  logic instr_valid = 1'h1;
  logic next_two_word = 1'h0;
  logic ext_set_en = 1'h1;
  logic [3:0] bank_select_register = 4'hA;
  logic [7:0] rd_data = 8'h00;
  isk_pkg::isk_addr_t rd_req;
  isk_pkg::isk_write_t wr_req;
  logic [7:0] wreg;
  logic flush, exec_busy, status_we;
  logic [1:0] phase_out;
  int error_cnt = 0;
  int check_count = 0;
  isk_row_t rows [6];
  isk_exec i_isk_exec (.clock, .rst, .instr, .instr_valid, .next_two_word, .ext_set_en,
    .bank_select_register, .rd_data, .rd_req, .wr_req, .wreg, .flush, .exec_busy,
    .status_we, .phase_out);
  // The clock toggles every half period.
  always #5 clock = ~clock;
  // One comparison, reported at once on a mismatch.
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'h1) begin
      error_cnt++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  // Puts one row's inputs on the pins at a clock edge.
  task automatic apply_row(input int k);
    instr <= rows[k].ins;
    rd_data <= rows[k].rd;
    next_two_word <= rows[k].tw;
  endtask : apply_row
  // The watchdog cuts a hang short.
  initial begin
    #20000;
    error_cnt++;
    report_and_stop();
  end
  // Rows hold word, operand, two-word flag, then wreg, discard and file write expected.
  initial begin
    rows = '{{16'h3C20, 8'hFF, 1'h0, 8'h00, 1'h1, 1'h0},
      {16'h3D80, 8'h41, 1'h0, 8'h42, 1'h0, 1'h0},
      {16'h4A70, 8'h10, 1'h0, 8'h42, 1'h1, 1'h1},
      {16'h4905, 8'hFF, 1'h0, 8'h00, 1'h0, 1'h0},
      {16'h2810, 8'h33, 1'h0, 8'h00, 1'h0, 1'h0},
      {16'h4B33, 8'h05, 1'h1, 8'h00, 1'h1, 1'h1}};
    repeat (10) @(posedge clock);
    rst <= 1'h0;
    apply_row(0);
    // Each word is put on the pins at the edge that opens its decode phase.
    for (int i = 0; i < 6; i++) begin
      repeat (4) @(posedge clock);
      if (!rows[i].fl && i < 5) apply_row(i + 1);
      #1;
      chk(wreg === rows[i].w, "wreg");
      chk(flush === rows[i].fl, "discard");
      chk(wr_req.valid === rows[i].wr, "file write");
      if (rows[i].wr) chk(wr_req.data === rows[i].rd + 8'h01, "data");
      chk(phase_out === 2'h3, "phase copy");
      if (rows[i].fl) begin
        repeat (rows[i].tw ? 7 : 3) @(posedge clock);
        #1;
        chk(flush === 1'h1 && exec_busy === 1'h1, "idle");
        @(posedge clock);
        if (i < 5) apply_row(i + 1);
      end
      $display("test %0d done", i);
    end
    // A word without valid is ignored; then the plain access bank with the extended set off.
    instr_valid <= 1'h0;
    instr <= 16'h3D80;
    rd_data <= 8'h41;
    repeat (4) @(posedge clock);
    instr_valid <= 1'h1;
    instr <= 16'h3C20;
    ext_set_en <= 1'h0;
    #1;
    chk(wreg === 8'h00 && flush === 1'h0 && wr_req.valid === 1'h0, "valid low");
    $display("test valid done");
    repeat (2) @(posedge clock);
    #1;
    chk(rd_req === isk_pkg::isk_addr_t'{1'h1, 1'h0, 4'h0, 8'h20}, "bank");
    repeat (2) @(posedge clock);
    #1;
    chk(wreg === 8'h42 && flush === 1'h0 && wr_req.valid === 1'h0, "no skip");
    $display("test access done");
    // A second reset in mid-run clears every output; decode resumes at the first edge.
    @(posedge clock);
    rst <= 1'h1;
    ext_set_en <= 1'h1;
    instr <= 16'h3D80;
    @(posedge clock);
    #1;
    chk(wreg === 8'h00 && flush === 1'h0 && exec_busy === 1'h0, "reset outputs");
    chk(wr_req === '0 && rd_req === '0 && phase_out === 2'h0, "reset requests");
    @(posedge clock);
    rst <= 1'h0;
    @(posedge clock);
    #1;
    chk(rd_req.valid === 1'h1 && phase_out === 2'h0, "first decode");
    @(posedge clock);
    #1;
    chk(rd_req.valid === 1'h1 && phase_out === 2'h1, "second edge");
    repeat (2) @(posedge clock);
    #1;
    chk(wreg === 8'h42 && wr_req.valid === 1'h0, "after reset");
    $display("test reset done");
    report_and_stop();
  end
endmodule : testbench
